// >>> rtl/tdp_pkg.sv
package tdp_pkg;

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int DW = 28; // full word data bus
	localparam int AW = 4; // register address
	localparam int HW = 16; // half-word access width
	localparam int HW_USED = 12; // used bits of the upper half
	localparam int NSTOP = 8; // stop inputs
	localparam int NGRP = 4; // stop gate groups, two stops each

	// ----------------------------------------
	// address map and fields
	// ----------------------------------------
	localparam logic [AW-1:0] FIFO_ADDR = 4'h8; // result fifo port
	localparam logic [AW-1:0] CFG_ADDR = 4'h5; // holds stop gate option
	localparam logic [AW-1:0] MODE_ADDR = 4'he; // bus width switch
	localparam logic [DW-1:0] HALF_VAL = 28'h0000010; // selects half-word
	localparam int STOP_GATE_BIT = 21; // stop gate after start
	localparam logic [DW-1:0] REG_RST = 28'h0000000; // register reset

	// ----------------------------------------
	// result fifo
	// ----------------------------------------
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int CNT_W = 4;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PS = 10000; // 100 mhz
	localparam int RST_PW_NS = 10; // least reset pulse width
	localparam int MRST_RFS_NS = 27; // master: blank after rise
	localparam int PRST_RFS_NS = 60; // partial: blank after rise
	localparam int RRS_NS = 13; // longest blank after fall
	localparam int STOP_DEAD_PS = 7400; // 7.4 ns longest dead time

	// least time, rounded up, one cycle at least
	function automatic int cyc_min(input int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// longest time, rounded down, one cycle at least
	function automatic int cyc_max(input int ps);
		int c;
		c = ps / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int BLK_W = 3; // blanking counter width
	localparam logic [BLK_W-1:0] MRST_CYC = BLK_W'(cyc_min(MRST_RFS_NS*1000));
	localparam logic [BLK_W-1:0] PRST_CYC = BLK_W'(cyc_min(PRST_RFS_NS*1000));
	localparam logic [BLK_W-1:0] RRS_CYC = BLK_W'(cyc_max(RRS_NS*1000));
	localparam logic [BLK_W-1:0] DEAD_CYC = BLK_W'(cyc_max(STOP_DEAD_PS));

	// host pacing, long enough for the three-stage input filters
	localparam int TMR_W = 4;
	localparam logic [TMR_W-1:0] STB_CYC = 4'ha; // strobe low
	localparam logic [TMR_W-1:0] REC_CYC = 4'h8; // strobe high gap
	localparam logic [TMR_W-1:0] RST_HOLD = TMR_W'(cyc_min(RST_PW_NS*1000) + 3);

	// host sequencer
	typedef enum logic [1:0] {
		H_IDLE,
		H_STB,
		H_REC
	} tdp_hstate_t;

endpackage

// >>> rtl/tdp_bus_if.sv
`timescale 1ns/100ps
interface tdp_bus_if;

	// ----------------------------------------
	// pins between host and device
	// ----------------------------------------
	logic [tdp_pkg::DW-1:0] data_d2h; // device data out
	logic data_oe_d; // device drives data
	logic [tdp_pkg::DW-1:0] data_h2d; // host data out
	logic data_oe_h; // host drives data
	logic [tdp_pkg::DW-1:0] data_bus; // resolved wire level
	logic [tdp_pkg::AW-1:0] addr; // register address
	logic chip_sel_low; // chip select, low active
	logic read_strobe_low; // read strobe, low active
	logic write_strobe_low; // write strobe, low active
	logic output_drive_hold_n; // low keeps device driving
	logic fifo_empty; // result fifo empty flag
	logic master_reset_pulse; // high active
	logic partial_reset_pulse; // high active

	// wire level; pull-down when nobody drives
	assign data_bus = data_oe_d ? data_d2h :
		(data_oe_h ? data_h2d : '0);

	modport dev (
		input data_bus, addr, chip_sel_low, read_strobe_low,
		input write_strobe_low, output_drive_hold_n,
		input master_reset_pulse, partial_reset_pulse,
		output data_d2h, data_oe_d, fifo_empty
	);

	modport host (
		input data_bus, fifo_empty,
		output data_h2d, data_oe_h, addr, chip_sel_low,
		output read_strobe_low, write_strobe_low, output_drive_hold_n,
		output master_reset_pulse, partial_reset_pulse
	);

endinterface

// >>> rtl/tdp_device_end.sv
`timescale 1ns/100ps
module tdp_device_end (
	input wire logic clk,
	input wire logic rstn,
	tdp_bus_if.dev bus,
	input wire logic res_valid,
	input wire logic [tdp_pkg::DW-1:0] res_data,
	output logic res_ready,
	input wire logic start_hit,
	input wire logic [tdp_pkg::NSTOP-1:0] stop_hit,
	input wire logic start_input_gate,
	input wire logic [tdp_pkg::NGRP-1:0] stop_group_gate,
	output logic start_acc,
	output logic [tdp_pkg::NSTOP-1:0] stop_acc,
	output logic half_mode,
	output logic stop_gate_after_start
);

	// ----------------------------------------
	// pin input filter
	// ----------------------------------------
	localparam int SW = 6 + tdp_pkg::AW + tdp_pkg::DW;
	// idle level: resets low, select and strobes high
	localparam logic [SW-1:0] PIN_IDLE =
		{2'h0, 4'hf, {(tdp_pkg::AW+tdp_pkg::DW){1'b0}}};

	logic [SW-1:0] pins; // raw pin vector
	logic [SW-1:0] s1_q, s2_q, s3_q; // three-stage chain
	logic [SW-1:0] f_q; // filtered level

	assign pins = {bus.master_reset_pulse, bus.partial_reset_pulse,
		bus.output_drive_hold_n, bus.chip_sel_low,
		bus.read_strobe_low, bus.write_strobe_low,
		bus.addr, bus.data_bus};

	// level moves only when stages two and three agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			f_q <= PIN_IDLE;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
		end
	end

	logic mrst_f, prst_f, hold_n_f; // filtered controls
	logic csn_f, rd_low_f, wr_low_f; // filtered strobes
	logic [tdp_pkg::AW-1:0] addr_f; // filtered address
	logic [tdp_pkg::DW-1:0] din_f; // filtered write data

	assign {mrst_f, prst_f, hold_n_f, csn_f, rd_low_f, wr_low_f,
		addr_f, din_f} = f_q;

	// ----------------------------------------
	// access edges
	// ----------------------------------------
	logic rd_act, wr_act; // access in progress
	logic rd_act_q, wr_act_q; // previous cycle
	logic rd_start, rd_end, wr_end; // access edges

	assign rd_act = !csn_f && !rd_low_f;
	assign wr_act = !csn_f && !wr_low_f;
	assign rd_start = rd_act && !rd_act_q;
	assign rd_end = !rd_act && rd_act_q;
	assign wr_end = !wr_act && wr_act_q;

	// edge history
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
		end else begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
		end
	end

	// ----------------------------------------
	// registers and pairing state
	// ----------------------------------------
	logic [tdp_pkg::DW-1:0] regs_q [2**tdp_pkg::AW]; // register file
	logic half_q; // half-word mode
	logic rd_ph_q, wr_ph_q; // second access of pair pending
	logic [tdp_pkg::HW-1:0] wlo_q; // staged lower write half
	logic [tdp_pkg::DW-1:0] wval; // complete write word
	logic wr_done; // word write complete
	logic [tdp_pkg::DW-1:0] wcap_q; // data last seen under the strobe

	// data and strobe leave the pins together; keep the strobed data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wcap_q <= '0;
		end else if (wr_act) begin
			wcap_q <= din_f;
		end
	end

	// upper half supplies only its low bits; top four dropped
	assign wval = half_q ?
		{wcap_q[tdp_pkg::HW_USED-1:0], wlo_q} : wcap_q;
	assign wr_done = wr_end && (!half_q || wr_ph_q);

	// store on strobe release while selected
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 2**tdp_pkg::AW; i++) begin
				regs_q[i] <= tdp_pkg::REG_RST;
			end
		end else if (wr_done && addr_f != tdp_pkg::FIFO_ADDR) begin
			regs_q[addr_f] <= wval;
		end
	end

	// mode switch on complete write to the mode address
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			half_q <= 1'b0;
		end else if (wr_done && addr_f == tdp_pkg::MODE_ADDR) begin
			half_q <= (wval == tdp_pkg::HALF_VAL);
		end
	end

	// pair phases; lower half always first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ph_q <= 1'b0;
			wr_ph_q <= 1'b0;
			wlo_q <= '0;
		end else begin
			if (rd_end && half_q) begin
				rd_ph_q <= !rd_ph_q;
			end
			if (wr_end && half_q) begin
				wr_ph_q <= !wr_ph_q;
				if (!wr_ph_q) begin
					wlo_q <= wcap_q[tdp_pkg::HW-1:0];
				end
			end
		end
	end

	// ----------------------------------------
	// result fifo
	// ----------------------------------------
	logic [tdp_pkg::DW-1:0] mem_q [tdp_pkg::FIFO_DEPTH]; // entries
	logic [tdp_pkg::PTR_W-1:0] wp_q, rp_q; // pointers
	logic [tdp_pkg::CNT_W-1:0] cnt_q, cnt_d; // fill level
	logic res_ready_q, empty_q; // flags
	logic rd_fifo_q; // current read targets fifo
	localparam int CNT_W = tdp_pkg::CNT_W; // local alias for casts
	logic push, pop;

	assign push = res_valid && res_ready_q;
	// first half of a pair pops, so empty can show early
	assign pop = rd_end && rd_fifo_q && (!half_q || !rd_ph_q)
		&& cnt_q != '0;
	assign cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);

	// storage and pointers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= res_data;
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_d;
		end
	end

	// flags follow next fill level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			res_ready_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			res_ready_q <= cnt_d != CNT_W'(tdp_pkg::FIFO_DEPTH);
			empty_q <= cnt_d == '0;
		end
	end

	// ----------------------------------------
	// read data and drivers
	// ----------------------------------------
	logic [tdp_pkg::DW-1:0] dout_q; // data to pins
	logic [tdp_pkg::DW-1:0] rhold_q; // word for upper half
	logic doe_q; // drive enable
	logic [tdp_pkg::DW-1:0] rword; // addressed word

	assign rword = (addr_f == tdp_pkg::FIFO_ADDR) ? mem_q[rp_q] :
		regs_q[addr_f];

	// load at read start; held afterwards for permanent drive
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dout_q <= '0;
			rhold_q <= '0;
			rd_fifo_q <= 1'b0;
		end else if (rd_start) begin
			if (!half_q) begin
				dout_q <= rword;
				rd_fifo_q <= addr_f == tdp_pkg::FIFO_ADDR;
			end else if (!rd_ph_q) begin
				dout_q <= {{(tdp_pkg::DW-tdp_pkg::HW){1'b0}},
					rword[tdp_pkg::HW-1:0]};
				rhold_q <= rword;
				rd_fifo_q <= addr_f == tdp_pkg::FIFO_ADDR;
			end else begin
				// upper half: top four bits read as zero
				dout_q <= {{(tdp_pkg::DW-tdp_pkg::HW_USED){1'b0}},
					rhold_q[tdp_pkg::DW-1:tdp_pkg::HW]};
			end
		end
	end

	// drive while hold low, otherwise during a read only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			doe_q <= 1'b0;
		end else begin
			doe_q <= !hold_n_f || rd_act;
		end
	end

	// ----------------------------------------
	// hit acceptance around resets
	// ----------------------------------------
	logic mrst_q, prst_q; // previous reset levels
	logic mrise, prise, rfall; // reset edges
	logic [tdp_pkg::BLK_W-1:0] blk_q; // blanking count
	logic blocked; // hits not accepted
	logic [tdp_pkg::BLK_W-1:0] dead_q; // stop dead time
	logic pst_q, start_q; // staged and final start
	logic [tdp_pkg::NSTOP-1:0] psp_q, stop_q; // staged and final stops

	assign mrise = mrst_f && !mrst_q;
	assign prise = prst_f && !prst_q;
	assign rfall = (!mrst_f && mrst_q) || (!prst_f && prst_q);
	assign blocked = mrst_f || prst_f || blk_q != '0;

	// expand group gates to stop lanes
	function automatic logic [tdp_pkg::NSTOP-1:0] lane_mask(
		input logic [tdp_pkg::NGRP-1:0] g);
		logic [tdp_pkg::NSTOP-1:0] m;
		m = '0;
		for (int i = 0; i < tdp_pkg::NSTOP; i++) begin
			m[i] = g[i/2];
		end
		return m;
	endfunction

	// blanking: load at rise, cut short at fall
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mrst_q <= 1'b0;
			prst_q <= 1'b0;
			blk_q <= '0;
		end else begin
			mrst_q <= mrst_f;
			prst_q <= prst_f;
			if (prise) begin
				blk_q <= tdp_pkg::PRST_CYC;
			end else if (mrise) begin
				blk_q <= tdp_pkg::MRST_CYC;
			end else if (rfall && blk_q > tdp_pkg::RRS_CYC) begin
				blk_q <= tdp_pkg::RRS_CYC;
			end else if (blk_q != '0) begin
				blk_q <= blk_q - 1'b1;
			end
		end
	end

	// stage one gates; stage two drops hits before partial reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pst_q <= 1'b0;
			psp_q <= '0;
			dead_q <= '0;
			start_q <= 1'b0;
			stop_q <= '0;
		end else begin
			pst_q <= start_hit && !start_input_gate && !blocked;
			psp_q <= stop_hit & ~lane_mask(stop_group_gate)
				& {tdp_pkg::NSTOP{!blocked && dead_q == '0}};
			if (start_hit && !start_input_gate && !blocked
				&& stop_gate_after_start) begin
				dead_q <= tdp_pkg::DEAD_CYC;
			end else if (dead_q != '0) begin
				dead_q <= dead_q - 1'b1;
			end
			start_q <= pst_q && !prise;
			stop_q <= psp_q & {tdp_pkg::NSTOP{!prise}};
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign stop_gate_after_start =
		regs_q[tdp_pkg::CFG_ADDR][tdp_pkg::STOP_GATE_BIT];
	assign half_mode = half_q;
	assign res_ready = res_ready_q;
	assign start_acc = start_q;
	assign stop_acc = stop_q;
	assign bus.data_d2h = dout_q;
	assign bus.data_oe_d = doe_q;
	assign bus.fifo_empty = empty_q;

endmodule

// >>> rtl/tdp_host_end.sv
`timescale 1ns/100ps
module tdp_host_end (
	input wire logic clk,
	input wire logic rstn,
	tdp_bus_if.host bus,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [tdp_pkg::AW-1:0] cmd_addr,
	input wire logic [tdp_pkg::DW-1:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [tdp_pkg::DW-1:0] rsp_data,
	output logic rsp_empty,
	input wire logic mrst_req,
	input wire logic prst_req,
	output logic half_mode
);

	// ----------------------------------------
	// input filter for device pins
	// ----------------------------------------
	localparam int SW = 1 + tdp_pkg::DW;
	localparam logic [SW-1:0] PIN_IDLE = {1'b1, {tdp_pkg::DW{1'b0}}};

	logic [SW-1:0] s1_q, s2_q, s3_q, f_q; // chain and level
	logic empty_f; // filtered empty flag
	logic [tdp_pkg::DW-1:0] data_f; // filtered bus

	// level moves only when stages two and three agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
			f_q <= PIN_IDLE;
		end else begin
			s1_q <= {bus.fifo_empty, bus.data_bus};
			s2_q <= s1_q;
			s3_q <= s2_q;
			f_q <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
		end
	end

	assign {empty_f, data_f} = f_q;

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	tdp_pkg::tdp_hstate_t st_q;
	logic [tdp_pkg::TMR_W-1:0] tmr_q; // phase timer
	logic wr_q, ph_q, half_q; // direction, pair phase, mode
	logic [tdp_pkg::AW-1:0] addr_q;
	logic [tdp_pkg::DW-1:0] wdat_q, dout_q; // command and pin data
	logic [tdp_pkg::HW-1:0] lo_q; // lower read half
	logic csn_q, rd_low_q, wr_low_q, oe_q, rv_q, re_q, rdy_q;
	logic [tdp_pkg::DW-1:0] rd_q; // response data
	logic [tdp_pkg::DW-1:0] piece; // data for this access

	// lower half first, upper half second
	assign piece = !half_q ? wdat_q : (ph_q ?
		{{(tdp_pkg::DW-tdp_pkg::HW_USED){1'b0}},
		wdat_q[tdp_pkg::DW-1:tdp_pkg::HW]} :
		{{(tdp_pkg::DW-tdp_pkg::HW){1'b0}},
		wdat_q[tdp_pkg::HW-1:0]});

	// one command per word; pairs in half mode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= tdp_pkg::H_IDLE;
			tmr_q <= '0;
			{wr_q, ph_q, half_q} <= 3'h0;
			addr_q <= '0;
			wdat_q <= '0;
			dout_q <= '0;
			lo_q <= '0;
			{csn_q, rd_low_q, wr_low_q} <= 3'h7;
			{oe_q, rv_q, re_q} <= 3'h0;
			rdy_q <= 1'b0;
			rd_q <= '0;
		end else begin
			rv_q <= 1'b0;
			case (st_q)
				tdp_pkg::H_IDLE: begin
					rdy_q <= 1'b1;
					if (cmd_valid && rdy_q) begin
						rdy_q <= 1'b0;
						if (!cmd_write && cmd_addr == tdp_pkg::FIFO_ADDR
							&& empty_f) begin
							// refused: no strobe on an empty fifo
							rv_q <= 1'b1;
							re_q <= 1'b1;
						end else begin
							wr_q <= cmd_write;
							addr_q <= cmd_addr;
							wdat_q <= cmd_wdata;
							ph_q <= 1'b0;
							re_q <= 1'b0;
							tmr_q <= '0;
							st_q <= tdp_pkg::H_STB;
						end
					end
				end
				tdp_pkg::H_STB: begin
					// select and strobe low together
					csn_q <= 1'b0;
					rd_low_q <= wr_q;
					wr_low_q <= !wr_q;
					oe_q <= wr_q;
					dout_q <= piece;
					tmr_q <= tmr_q + 1'b1;
					if (tmr_q == tdp_pkg::STB_CYC) begin
						{csn_q, rd_low_q, wr_low_q} <= 3'h7;
						oe_q <= 1'b0;
						if (half_q && !ph_q) begin
							lo_q <= data_f[tdp_pkg::HW-1:0];
						end else if (half_q) begin
							rd_q <= {data_f[tdp_pkg::HW_USED-1:0], lo_q};
						end else begin
							rd_q <= data_f;
						end
						tmr_q <= '0;
						st_q <= tdp_pkg::H_REC;
					end
				end
				tdp_pkg::H_REC: begin
					// gap lets the empty flag settle; no dummy strobe
					tmr_q <= tmr_q + 1'b1;
					if (tmr_q == tdp_pkg::REC_CYC) begin
						tmr_q <= '0;
						if (half_q && !ph_q) begin
							// second half even if empty rose
							ph_q <= 1'b1;
							st_q <= tdp_pkg::H_STB;
						end else begin
							rv_q <= 1'b1;
							if (wr_q) begin
								rd_q <= '0;
							end
							if (wr_q && addr_q == tdp_pkg::MODE_ADDR) begin
								half_q <= wdat_q == tdp_pkg::HALF_VAL;
							end
							st_q <= tdp_pkg::H_IDLE;
						end
					end
				end
				default: st_q <= tdp_pkg::H_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// reset pulses
	// ----------------------------------------
	logic mp_q, pp_q; // pulse levels
	logic [tdp_pkg::TMR_W-1:0] rc_q; // pulse width count

	// pulse held past the least width and the device filter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mp_q <= 1'b0;
			pp_q <= 1'b0;
			rc_q <= '0;
		end else if (rc_q != '0) begin
			rc_q <= rc_q - 1'b1;
			if (rc_q == 4'h1) begin
				mp_q <= 1'b0;
				pp_q <= 1'b0;
			end
		end else if (mrst_req || prst_req) begin
			mp_q <= mrst_req;
			pp_q <= prst_req;
			rc_q <= tdp_pkg::RST_HOLD;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign bus.output_drive_hold_n = 1'b1;
	assign bus.data_h2d = dout_q;
	assign bus.data_oe_h = oe_q;
	assign bus.addr = addr_q;
	assign bus.chip_sel_low = csn_q;
	assign bus.read_strobe_low = rd_low_q;
	assign bus.write_strobe_low = wr_low_q;
	assign bus.master_reset_pulse = mp_q;
	assign bus.partial_reset_pulse = pp_q;
	assign cmd_ready = rdy_q;
	assign rsp_valid = rv_q;
	assign rsp_data = rd_q;
	assign rsp_empty = re_q;
	assign half_mode = half_q;

endmodule

// >>> tb/tdp_bus_assertions.sv
`timescale 1ns/100ps
module tdp_bus_assertions (
	input logic clk,
	input logic rstn,
	input logic [tdp_pkg::DW-1:0] data_d2h,
	input logic data_oe_d,
	input logic data_oe_h,
	input logic [tdp_pkg::AW-1:0] addr,
	input logic chip_sel_low,
	input logic read_strobe_low,
	input logic write_strobe_low,
	input logic output_drive_hold_n,
	input logic master_reset_pulse,
	input logic partial_reset_pulse
);
	// ----------------------------------------
	// read cycle steps
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// strobe falls while selected
	sequence rd_go;
		$fell(read_strobe_low) && !chip_sel_low;
	endsequence
	// strobe released, drive not held
	sequence rd_end;
		$rose(read_strobe_low) && output_drive_hold_n;
	endsequence
	// strobe still low since last edge
	sequence rd_on;
		!read_strobe_low && $past(!read_strobe_low);
	endsequence

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_OE_RISE: assert property (rd_go |-> ##[2:6] data_oe_d)
		else $error("device drive late after read strobe");
	AST_OE_DROP: assert property (rd_end |-> ##[1:8] !data_oe_d)
		else $error("device drive not released");
	AST_OE_CAUSE: assert property ($rose(data_oe_d) && output_drive_hold_n
		|-> !read_strobe_low && !chip_sel_low)
		else $error("device drive without read");
	AST_NO_FIGHT: assert property (!(data_oe_d && data_oe_h))
		else $error("both ends drive data");
	AST_HOLD_DATA: assert property (data_oe_d && $past(data_oe_d)
		|-> $stable(data_d2h))
		else $error("read data changed while driven");
	AST_ONE_STROBE: assert property (!(!read_strobe_low
		&& !write_strobe_low))
		else $error("read and write strobe together");
	AST_SEL_STROBE: assert property (!read_strobe_low
		|| !write_strobe_low |-> !chip_sel_low)
		else $error("strobe without select");
	AST_WR_HOST: assert property (!write_strobe_low
		|-> data_oe_h && output_drive_hold_n)
		else $error("write without host drive");
	AST_ADDR_HOLD: assert property (rd_on |-> $stable(addr))
		else $error("address moved in read");
	AST_MRST_W: assert property ($rose(master_reset_pulse)
		|-> master_reset_pulse[*2])
		else $error("master reset pulse short");
	AST_PRST_W: assert property ($rose(partial_reset_pulse)
		|-> partial_reset_pulse[*2])
		else $error("partial reset pulse short");
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk, rstn, cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_empty;
	logic res_valid, res_ready, start_hit, start_input_gate, start_acc;
	logic mrst_req, prst_req, hm_d, hm_h, sg;
	logic [3:0] cmd_addr, stop_group_gate;
	logic [27:0] cmd_wdata, res_data, rsp_data;
	logic [7:0] stop_hit, stop_acc;
	int err_count, samples_checked;
	tdp_bus_if tdp_bus_if_inst ();
	tdp_device_end tdp_device_end_inst (.clk(clk), .rstn(rstn),
		.bus(tdp_bus_if_inst.dev), .res_valid(res_valid),
		.res_data(res_data), .res_ready(res_ready), .start_hit(start_hit),
		.stop_hit(stop_hit), .start_input_gate(start_input_gate),
		.stop_group_gate(stop_group_gate), .start_acc(start_acc),
		.stop_acc(stop_acc), .half_mode(hm_d), .stop_gate_after_start(sg));
	tdp_host_end tdp_host_end_inst (.clk(clk), .rstn(rstn),
		.bus(tdp_bus_if_inst.host), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_empty(rsp_empty), .mrst_req(mrst_req), .prst_req(prst_req),
		.half_mode(hm_h));
	tdp_bus_assertions tdp_bus_assertions_inst (.clk(clk), .rstn(rstn),
		.data_d2h(tdp_bus_if_inst.data_d2h),
		.data_oe_d(tdp_bus_if_inst.data_oe_d),
		.data_oe_h(tdp_bus_if_inst.data_oe_h), .addr(tdp_bus_if_inst.addr),
		.chip_sel_low(tdp_bus_if_inst.chip_sel_low),
		.read_strobe_low(tdp_bus_if_inst.read_strobe_low),
		.write_strobe_low(tdp_bus_if_inst.write_strobe_low),
		.output_drive_hold_n(tdp_bus_if_inst.output_drive_hold_n),
		.master_reset_pulse(tdp_bus_if_inst.master_reset_pulse),
		.partial_reset_pulse(tdp_bus_if_inst.partial_reset_pulse));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// compare and count
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one host command, waits for its answer
	task automatic cmd(input logic w, input logic [3:0] a,
		input logic [27:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 99) begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 199) begin
			@(negedge clk);
			n++;
		end
		if (n >= 199) begin
			err_count++;
			$display("mismatch %0t command timed out", $time);
		end
	endtask
	// read and judge; data skipped when refused
	task automatic rd(input logic [3:0] a, input logic [27:0] d,
		input logic e);
		cmd(1'b0, a, 28'h0);
		chk(28'(rsp_empty), 28'(e));
		if (!e)
			chk(rsp_data, d);
	endtask
	// load one result, let empty settle
	task automatic push(input logic [27:0] v);
		@(negedge clk);
		res_valid = 1'b1;
		res_data = v;
		@(negedge clk);
		res_valid = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	// start and stops in one cycle, stops p1 in the next
	task automatic hits(input logic s, input logic [7:0] p0,
		input logic [7:0] p1, input logic [8:0] exp);
		logic [8:0] acc;
		acc = 9'h0;
		@(negedge clk);
		start_hit = s;
		stop_hit = p0;
		@(negedge clk);
		start_hit = 1'b0;
		stop_hit = p1;
		acc = acc | {start_acc, stop_acc};
		repeat (6) begin
			@(negedge clk);
			stop_hit = 8'h0;
			acc = acc | {start_acc, stop_acc};
		end
		chk(28'(acc), 28'(exp));
	endtask
	// reset pulse then hits inside and after blanking
	task automatic rst_hits(input logic m);
		@(negedge clk);
		mrst_req = m;
		prst_req = !m;
		@(negedge clk);
		mrst_req = 1'b0;
		prst_req = 1'b0;
		repeat (3) @(negedge clk);
		hits(1'b1, 8'h0, 8'h0, 9'h0);
		repeat (20) @(negedge clk);
		hits(1'b1, 8'h0, 8'h0, 9'h100);
	endtask
	task print_verdict;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_gates;
		hits(1'b1, 8'h0, 8'hff, 9'h1ff);
		start_input_gate = 1'b1;
		stop_group_gate = 4'h5;
		hits(1'b1, 8'hff, 8'h0, 9'h0cc);
		start_input_gate = 1'b0;
		stop_group_gate = 4'h0;
		$display("gates done");
	endtask
	task automatic t_option;
		cmd(1'b1, tdp_pkg::CFG_ADDR, 28'h0a5a5a5);
		rd(tdp_pkg::CFG_ADDR, 28'h0a5a5a5, 1'b0);
		chk(28'(sg), 28'h1);
		hits(1'b1, 8'h0, 8'hff, 9'h100);
		hits(1'b1, 8'hff, 8'h0, 9'h1ff);
		cmd(1'b1, tdp_pkg::CFG_ADDR, 28'h0);
		$display("option done");
	endtask
	task automatic t_fifo;
		push(28'h1234567);
		push(28'hfedcba9);
		rd(tdp_pkg::FIFO_ADDR, 28'h1234567, 1'b0);
		rd(tdp_pkg::FIFO_ADDR, 28'hfedcba9, 1'b0);
		chk(28'(tdp_bus_if_inst.fifo_empty), 28'h1);
		chk(28'(res_ready), 28'h1);
		rd(tdp_pkg::FIFO_ADDR, 28'h0, 1'b1);
		$display("fifo done");
	endtask
	task automatic t_half;
		cmd(1'b1, tdp_pkg::MODE_ADDR, tdp_pkg::HALF_VAL);
		chk(28'({hm_d, hm_h}), 28'h3);
		push(28'habc1234);
		rd(tdp_pkg::FIFO_ADDR, 28'habc1234, 1'b0);
		rd(tdp_pkg::FIFO_ADDR, 28'h0, 1'b1);
		rd(tdp_pkg::MODE_ADDR, tdp_pkg::HALF_VAL, 1'b0);
		cmd(1'b1, tdp_pkg::MODE_ADDR, 28'h0);
		chk(28'({hm_d, hm_h}), 28'h0);
		$display("half done");
	endtask

	// ----------------------------------------
	// clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rstn, cmd_valid, cmd_write, res_valid, start_hit} = '0;
		{start_input_gate, mrst_req, prst_req} = '0;
		{cmd_addr, stop_group_gate, stop_hit} = '0;
		{cmd_wdata, res_data} = '0;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		t_gates();
		t_option();
		t_fifo();
		t_half();
		rst_hits(1'b1);
		rst_hits(1'b0);
		$display("resets done");
		print_verdict();
	end
	// scenarios need well under 3000 cycles
	initial begin
		#300000;
		err_count++;
		$display("mismatch %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
